// File: ppb_cfg.sv
// Mode and direction holder loaded by the setup command.
`timescale 1ns/10ps
`default_nettype none
module ppb_cfg
   import ppb_pkg::*;
(
   // Clock and reset
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_ce,
   // Setup command
   input  wire logic       i_cmd_valid,
   input  wire logic [7:0] i_cmd_mode,
   input  wire logic [7:0] i_cmd_dir,
   // Held configuration
   output ppb_cfg_s        o_cfg
);
   ppb_cfg_s st_reg;
   ppb_cfg_s st_next;

   assign o_cfg = st_reg;

   always_comb begin
      st_next = st_reg;
      if (i_cmd_valid) begin
         st_next.mode = i_cmd_mode;
         // Direction only changes on a new setup command.
         st_next.dir  = i_cmd_dir;
         if (i_cmd_mode == PPB_MODE_RESET) begin
            st_next.dir = PPB_DIR_RST;
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_reg.mode <= PPB_MODE_RESET;
         st_reg.dir  <= PPB_DIR_RST;
      end else if (i_ce) begin
         st_reg <= st_next;
      end
   end
endmodule
`default_nettype wire

// File: ppb_pin_model.sv
// External logic model that resolves the eight parallel pins.
`timescale 1ns/10ps
`default_nettype none
module ppb_pin_model (
   // Device side
   input  wire logic [7:0] i_out,
   input  wire logic [7:0] i_oe_n,
   // Outside drive
   input  wire logic [7:0] i_ext,
   output logic      [7:0] o_level
);
   // A pin the port drives shows its value; an input pin shows the outside.
   always_comb begin
      o_level = (i_out & ~i_oe_n) | (i_ext & i_oe_n);
   end
endmodule
`default_nettype wire

// File: ppb_pkg.sv
// Package with shared constants and types for the parallel pin port.
package ppb_pkg;

   localparam int          PPB_W           = 8;
   localparam logic [7:0]  PPB_MODE_RESET  = 8'h00;
   localparam logic [7:0]  PPB_MODE_FREE   = 8'h01;
   localparam logic [7:0]  PPB_MODE_LOCK   = 8'h04;
   localparam logic [7:0]  PPB_DIR_RST     = 8'h00;
   localparam logic [7:0]  PPB_OUT_RST     = 8'h00;
   localparam int          PPB_SETUP_CYC   = 1;
   localparam logic [1:0]  PPB_SETUP_CNT   = 2'(PPB_SETUP_CYC);

   typedef struct packed {
      logic [7:0] mode;
      logic [7:0] dir;
   } ppb_cfg_s;

   typedef enum logic [4:0] {
      PPB_IDLE   = 5'h01,
      PPB_SAMPLE = 5'h02,
      PPB_DRIVE  = 5'h04,
      PPB_SETUP  = 5'h08,
      PPB_STROBE = 5'h10
   } ppb_state_e;

   typedef struct packed {
      logic [1:0] cnt;
      logic       full0;
      logic       full1;
      logic [7:0] d0;
      logic [7:0] d1;
   } ppb_buf_s;

endpackage

// File: ppb_port.sv
// Top of the eight-pin parallel port with free-running and lock-step modes.
// Overview of operation
// - Free mode brings both strobes to pins.
// - Free mode moves host bytes to output pins.
// - Each pin has its own direction bit.
// - Free mode pacing follows baud ticks.
// - Pins change only on new byte and tick.
// - Mode value 01 selects free mode.
// - Lock mode updates pins on host byte.
// - Lock mode samples only after a write.
// - Lock mode waits for room for sample.
// - Sample before drive; returns lag one byte.
// - Mode value 04 selects lock mode.
// - Read pins, sample strobe low, forward sample.
// - Sample strobe high, outputs take new byte.
// - One setup cycle, then update strobe pulse.
// - Setup command loads direction mask, held.
// - Mode value 00 returns to reset state.
`timescale 1ns/10ps
`default_nettype none
module ppb_port
   import ppb_pkg::*;
(
   // Clock, reset and enable
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_ce,
   // Pin mode command
   input  wire logic       i_cmd_valid,
   input  wire logic [7:0] i_cmd_mode,
   input  wire logic [7:0] i_cmd_dir,
   // Baud tick
   input  wire logic       i_baud_tick,
   // Host to pins stream
   input  wire logic       i_h2p_valid,
   input  wire logic [7:0] i_h2p_data,
   output logic            o_h2p_ready,
   // Pins to host stream
   output logic            o_p2h_valid,
   output logic [7:0]      o_p2h_data,
   input  wire logic       i_p2h_ready,
   // Parallel pins
   input  wire logic [7:0] i_pin,
   output logic [7:0]      o_pin,
   output logic [7:0]      o_pin_oe_n,
   // Strobes
   output logic            o_pin_sample_strobe_n,
   output logic            o_pin_update_strobe_n
);
   typedef struct packed {
      ppb_state_e state;
      logic [1:0] cnt;
      logic [7:0] out;
      logic [7:0] nbyte;
      logic [7:0] oe_n;
      logic       rd_n;
      logic       wr_n;
      logic       p2h_valid;
      logic [7:0] p2h_data;
      logic       h2p_ready;
   } ppb_core_s;

   ppb_core_s st_reg;
   ppb_core_s st_next;
   ppb_cfg_s  cfg;
   logic      b_valid;
   logic [7:0] b_data;
   logic      b_pop;
   logic      b_ready;
   logic      free_md;
   logic      lock_md;
   logic      mode_clr;
   logic [1:0] h2p_occ;

   assign free_md  = (cfg.mode == PPB_MODE_FREE);
   assign lock_md  = (cfg.mode == PPB_MODE_LOCK);
   assign mode_clr = i_cmd_valid && (i_cmd_mode == PPB_MODE_RESET);

   // Occupancy the buffer will hold after this edge. The registered ready
   // must show next cycle's room; a copy of the old flag would lag by one
   // cycle and let the host push into a full buffer and lose the byte.
   assign h2p_occ  = 2'(b_valid) + 2'(!b_ready) - 2'(b_pop)
                   + 2'(i_h2p_valid && b_ready);

   ppb_cfg u_cfg (
      .i_sys_clk   (i_sys_clk),
      .i_rst_n     (i_rst_n),
      .i_ce        (i_ce),
      .i_cmd_valid (i_cmd_valid),
      .i_cmd_mode  (i_cmd_mode),
      .i_cmd_dir   (i_cmd_dir),
      .o_cfg       (cfg)
   );

   // The buffer absorbs a host byte while the core is busy or stalled.
   ppb_skid u_buf (
      .i_sys_clk (i_sys_clk),
      .i_rst_n   (i_rst_n),
      .i_ce      (i_ce),
      .i_clr     (mode_clr),
      .i_valid   (i_h2p_valid),
      .i_data    (i_h2p_data),
      .o_ready   (b_ready),
      .o_valid   (b_valid),
      .o_data    (b_data),
      .i_ready   (b_pop)
   );

   // A byte leaves the buffer only in idle, paced by mode conditions.
   always_comb begin
      b_pop = 1'b0;
      if (st_reg.state == PPB_IDLE && b_valid) begin
         if (free_md) begin
            b_pop = i_baud_tick;
         end else if (lock_md) begin
            b_pop = !st_reg.p2h_valid || i_p2h_ready;
         end
      end
   end

   always_comb begin
      st_next = st_reg;
      st_next.h2p_ready = mode_clr || (h2p_occ != 2'h2);
      st_next.oe_n = ~cfg.dir;
      if (st_reg.p2h_valid && i_p2h_ready) begin
         st_next.p2h_valid = 1'b0;
      end
      case (st_reg.state)
         PPB_IDLE: begin
            st_next.rd_n = 1'b1;
            st_next.wr_n = 1'b1;
            if (b_pop && free_md) begin
               // Byte goes straight to the output pins on the tick.
               st_next.out  = b_data;
               st_next.wr_n = 1'b0;
               st_next.rd_n = 1'b0;
            end else if (b_pop && lock_md) begin
               st_next.nbyte = b_data;
               st_next.wr_n  = 1'b1;
               st_next.state = PPB_SAMPLE;
            end
         end
         PPB_SAMPLE: begin
            // Pins are read before the new byte is driven.
            st_next.rd_n      = 1'b0;
            st_next.p2h_data  = i_pin;
            st_next.p2h_valid = 1'b1;
            st_next.state     = PPB_DRIVE;
         end
         PPB_DRIVE: begin
            st_next.rd_n  = 1'b1;
            st_next.out   = st_reg.nbyte;
            st_next.cnt   = PPB_SETUP_CNT;
            st_next.state = PPB_SETUP;
         end
         PPB_SETUP: begin
            st_next.cnt = st_reg.cnt - 2'h1;
            if (st_reg.cnt == 2'h1) begin
               st_next.wr_n  = 1'b0;
               st_next.state = PPB_STROBE;
            end
         end
         PPB_STROBE: begin
            st_next.wr_n  = 1'b1;
            st_next.state = PPB_IDLE;
         end
         default: begin
            st_next.state = PPB_IDLE;
         end
      endcase
      if (mode_clr) begin
         st_next.state     = PPB_IDLE;
         st_next.out       = PPB_OUT_RST;
         st_next.rd_n      = 1'b1;
         st_next.wr_n      = 1'b1;
         st_next.p2h_valid = 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_reg           <= '0;
         st_reg.state     <= PPB_IDLE;
         st_reg.oe_n      <= 8'hFF;
         st_reg.out       <= PPB_OUT_RST;
         st_reg.rd_n      <= 1'b1;
         st_reg.wr_n      <= 1'b1;
      end else if (i_ce) begin
         st_reg <= st_next;
      end
   end

   assign o_h2p_ready           = st_reg.h2p_ready;
   assign o_p2h_valid           = st_reg.p2h_valid;
   assign o_p2h_data            = st_reg.p2h_data;
   assign o_pin                 = st_reg.out;
   assign o_pin_oe_n            = st_reg.oe_n;
   assign o_pin_sample_strobe_n = st_reg.rd_n;
   assign o_pin_update_strobe_n = st_reg.wr_n;

   property p_free_tick;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_ce && st_reg.state == PPB_IDLE && free_md && b_valid && i_baud_tick
       && !i_cmd_valid) |=> (o_pin == $past(b_data) && !o_pin_update_strobe_n);
   endproperty
   a_free_tick: assert property (p_free_tick)
      else $error("Free mode byte not driven on tick.");

   property p_no_tick;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_ce && free_md && !i_baud_tick && !i_cmd_valid
       && st_reg.state == PPB_IDLE) |=> $stable(o_pin);
   endproperty
   a_no_tick: assert property (p_no_tick)
      else $error("Pins changed without a baud tick.");

   property p_dir;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_ce && !i_cmd_valid) ##1 (i_ce && !i_cmd_valid)
      |=> (o_pin_oe_n == ~cfg.dir);
   endproperty
   a_dir: assert property (p_dir)
      else $error("Output enables differ from direction mask.");

   property p_lock_seq;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_ce && st_reg.state == PPB_SAMPLE && !i_cmd_valid) ##1
      (i_ce && !i_cmd_valid)[*3]
      |-> $past(o_pin_sample_strobe_n, 2) == 1'b0
          && o_pin_update_strobe_n == 1'b0;
   endproperty
   a_lock_seq: assert property (p_lock_seq)
      else $error("Lock step strobe order wrong.");

   property p_sample;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_ce && st_reg.state == PPB_SAMPLE && !i_cmd_valid)
      |=> (o_p2h_valid && o_p2h_data == $past(i_pin) && !o_pin_sample_strobe_n);
   endproperty
   a_sample: assert property (p_sample)
      else $error("Pin sample not captured.");

   property p_drive;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_ce && st_reg.state == PPB_DRIVE && !i_cmd_valid)
      |=> (o_pin == $past(st_reg.nbyte) && o_pin_sample_strobe_n);
   endproperty
   a_drive: assert property (p_drive)
      else $error("New byte not driven after capture.");

   property p_room;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (lock_md && st_reg.p2h_valid && !i_p2h_ready) |-> !b_pop;
   endproperty
   a_room: assert property (p_room)
      else $error("Byte taken without room for sample.");

   property p_no_spont;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_ce && lock_md && st_reg.state == PPB_IDLE && !b_pop)
      |=> !(o_p2h_valid && !$past(o_p2h_valid));
   endproperty
   a_no_spont: assert property (p_no_spont)
      else $error("Sample sent without a write.");

   property p_clr;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_ce && mode_clr) |=> (st_reg.state == PPB_IDLE && o_pin_update_strobe_n
                             && o_pin_sample_strobe_n && !o_p2h_valid);
   endproperty
   a_clr: assert property (p_clr)
      else $error("Mode zero did not return to reset state.");

   property p_free_rel;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_ce && free_md && !o_pin_update_strobe_n && !b_pop && !i_cmd_valid)
      |=> (o_pin_update_strobe_n && o_pin_sample_strobe_n);
   endproperty
   a_free_rel: assert property (p_free_rel)
      else $error("Free mode strobes not released.");

   // The new byte must stand one full cycle before the update strobe.
   property p_upd_setup;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_ce && st_reg.state == PPB_SETUP && !i_cmd_valid)
      |=> (!o_pin_update_strobe_n && $stable(o_pin));
   endproperty
   a_upd_setup: assert property (p_upd_setup)
      else $error("Update strobe without data setup cycle.");

   property p_upd_rel;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_ce && st_reg.state == PPB_STROBE && !i_cmd_valid)
      |=> (o_pin_update_strobe_n && st_reg.state == PPB_IDLE);
   endproperty
   a_upd_rel: assert property (p_upd_rel)
      else $error("Update strobe not released.");

   property p_ready_mirror;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_ce |=> (o_h2p_ready == b_ready);
   endproperty
   a_ready_mirror: assert property (p_ready_mirror)
      else $error("Host ready differs from buffer room.");

   c_clr: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      mode_clr && b_valid);
   c_free: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      free_md && b_pop);
   c_lock: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      st_reg.state == PPB_STROBE);
   c_stall: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      lock_md && b_valid && o_p2h_valid && !i_p2h_ready);
endmodule
`default_nettype wire

// File: ppb_skid.sv
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/10ps
`default_nettype none
module ppb_skid
   import ppb_pkg::*;
(
   // Clock and reset
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_ce,
   input  wire logic       i_clr,
   // Filling side
   input  wire logic       i_valid,
   input  wire logic [7:0] i_data,
   output logic            o_ready,
   // Draining side
   output logic            o_valid,
   output logic [7:0]      o_data,
   input  wire logic       i_ready
);
   ppb_buf_s st_reg;
   ppb_buf_s st_next;
   logic     push;
   logic     pop;

   assign o_ready = !st_reg.full1;
   assign o_valid = st_reg.full0;
   assign o_data  = st_reg.d0;
   assign push    = i_valid && !st_reg.full1;
   assign pop     = i_ready && st_reg.full0;

   always_comb begin
      st_next = st_reg;
      st_next.cnt = '0;
      if (pop) begin
         st_next.d0    = st_reg.d1;
         st_next.full0 = st_reg.full1;
         st_next.full1 = 1'b0;
      end
      if (push) begin
         if (!st_next.full0) begin
            st_next.d0    = i_data;
            st_next.full0 = 1'b1;
         end else begin
            st_next.d1    = i_data;
            st_next.full1 = 1'b1;
         end
      end
      if (i_clr) begin
         st_next.full0 = 1'b0;
         st_next.full1 = 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_reg <= '0;
      end else if (i_ce) begin
         st_reg <= st_next;
      end
   end
endmodule
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the parallel pin port.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import ppb_pkg::*;
   logic        clk, rst_n, cmd_v, tick, h_v, p_rdy;
   logic [7:0]  cmd_m, cmd_d, h_d, ext, lvl, dir, prev, held, b;
   logic        h_rdy, p_v, s_n, u_n;
   logic [7:0]  p_d, pout, oe_n;
   logic [31:0] rs, rs2;
   logic [1:0]  rmode;
   logic [7:0]  expq[$];
   int          err_total, checks_done, k;

   ppb_port i_ppb_port (.i_sys_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1),
      .i_cmd_valid(cmd_v), .i_cmd_mode(cmd_m), .i_cmd_dir(cmd_d),
      .i_baud_tick(tick), .i_h2p_valid(h_v), .i_h2p_data(h_d),
      .o_h2p_ready(h_rdy), .o_p2h_valid(p_v), .o_p2h_data(p_d),
      .i_p2h_ready(p_rdy), .i_pin(lvl), .o_pin(pout), .o_pin_oe_n(oe_n),
      .o_pin_sample_strobe_n(s_n), .o_pin_update_strobe_n(u_n));
   ppb_pin_model i_ppb_pin_model (.i_out(pout), .i_oe_n(oe_n),
      .i_ext(ext), .o_level(lvl));

   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   task automatic rnd(output logic [7:0] r);
      rs = xs(rs);
      r = rs[7:0];
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic fail(input string what);
      err_total++;
      $display("wrong value at %0t: %s", $time, what);
      summarize();
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                        input string what);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: %s %h not %h", $time, what, seen, exp);
      end
   endtask

   task automatic cmd(input logic [7:0] m, input logic [7:0] d);
      cmd_v <= 1'b1;
      cmd_m <= m;
      cmd_d <= d;
      @(posedge clk);
      cmd_v <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   // Leaves valid high so back-to-back beats never toggle it in one step.
   task automatic push(input logic [7:0] v);
      logic r;
      int   n;
      h_v <= 1'b1;
      h_d <= v;
      r = 1'b0;
      for (n = 0; n < 300 && !r; n++) begin
         @(negedge clk);
         r = h_rdy;
         @(posedge clk);
      end
      if (r !== 1'b1) fail("host byte never taken");
   endtask

   // The sample is taken before the new byte is driven, one byte behind.
   task automatic send(input logic [7:0] v);
      expq.push_back((prev & dir) | (ext & ~dir));
      prev = v;
      push(v);
   endtask

   task automatic drain;
      int n;
      for (n = 0; n < 800 && expq.size() > 0; n++) @(posedge clk);
      if (expq.size() > 0) fail("samples missing");
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      rs2 = xs(rs2);
      p_rdy <= (rmode == 2'd2) ? rs2[3] : rmode[0];
   end

   always @(posedge clk) begin
      if (rst_n && p_v && p_rdy) begin
         if (expq.size() == 0) begin
            err_total++;
            $display("wrong value at %0t: sample with no write", $time);
         end else begin
            check(p_d, expq.pop_front(), "sample");
         end
      end
   end

   initial begin
      repeat (50000) @(posedge clk);
      fail("run too long");
   end

   initial begin
      rs = 32'hB6BB;
      rs2 = 32'h1F3D;
      rst_n = 1'b0;
      cmd_v = 1'b0;
      cmd_m = 8'h00;
      cmd_d = 8'h00;
      tick = 1'b0;
      h_v = 1'b0;
      h_d = 8'h00;
      ext = 8'h00;
      p_rdy = 1'b1;
      rmode = 2'd1;
      err_total = 0;
      checks_done = 0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(negedge clk);
      check(pout, PPB_OUT_RST, "reset pins");
      check(oe_n, ~PPB_DIR_RST, "reset enables");
      check({6'h00, s_n, u_n}, 8'h03, "reset strobes");
      $display("test reset done");
      @(posedge clk);
      dir = 8'hFF;
      prev = PPB_OUT_RST;
      cmd(PPB_MODE_LOCK, dir);
      @(negedge clk);
      check(oe_n, ~dir, "direction mask");
      @(posedge clk);
      send(8'h55);
      send(8'hAA);
      send(8'hAA);
      h_v <= 1'b0;
      drain();
      @(negedge clk);
      check(pout, 8'hAA, "lock pins");
      $display("test lock order done");
      @(posedge clk);
      rmode = 2'd0;
      send(8'h11);
      send(8'h22);
      send(8'h33);
      h_v <= 1'b0;
      repeat (30) @(posedge clk);
      @(negedge clk);
      check(pout, 8'h11, "stalled pins");
      rmode = 2'd2;
      @(posedge clk);
      drain();
      $display("test lock stall done");
      cmd(PPB_MODE_RESET, 8'h00);
      @(negedge clk);
      check(oe_n, 8'hFF, "cleared enables");
      check(pout, PPB_OUT_RST, "cleared pins");
      @(posedge clk);
      prev = PPB_OUT_RST;
      rnd(dir);
      rnd(b);
      ext <= b;
      cmd(PPB_MODE_LOCK, dir);
      for (k = 0; k < 8; k++) begin
         rnd(b);
         send(b);
      end
      h_v <= 1'b0;
      drain();
      $display("test mixed directions done");
      rmode = 2'd1;
      cmd(PPB_MODE_FREE, 8'hFF);
      @(negedge clk);
      held = pout;
      @(posedge clk);
      push(~held);
      h_v <= 1'b0;
      repeat (10) @(posedge clk);
      @(negedge clk);
      check(pout, held, "pins without tick");
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      for (k = 0; k < 20; k++) begin
         @(negedge clk);
         if (u_n === 1'b0) break;
      end
      check(pout, ~held, "paced pins");
      check({7'h00, s_n}, 8'h00, "sample strobe pin");
      @(negedge clk);
      check({6'h00, s_n, u_n}, 8'h03, "strobes released");
      $display("test free mode done");
      @(posedge clk);
      cmd(PPB_MODE_RESET, 8'h00);
      summarize();
   end
endmodule
`default_nettype wire
